/* File: rtl/dual_comparator_pkg.sv */
package dual_comparator_pkg;
  // Byte addresses of the registers on the AXI4-Lite bus
  localparam logic [3:0] first_control_addr = 4'h0;
  localparam logic [3:0] second_control_addr = 4'h4;
  localparam logic [3:0] misc_control_addr = 4'h8;
  // Control register fields
  localparam int enable_bit_pos = 7;
  localparam int output_state_pos = 6;
  localparam int rising_flag_pos = 5;
  localparam int falling_flag_pos = 4;
  localparam int pos_hyst_lsb = 2;
  localparam int neg_hyst_lsb = 0;
  localparam logic [7:0] control_reset = 8'h00;
  // Miscellaneous register fields
  localparam int reset_source_pos = 0;
  localparam int first_push_pull_pos = 1;
  localparam int second_push_pull_pos = 2;
  localparam logic [7:0] misc_reset = 8'h00;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // Settling time after enable
  localparam int settle_time_us = 20;
  localparam int clock_mhz = 100;
  localparam int settle_cycles = settle_time_us * clock_mhz;
endpackage : dual_comparator_pkg

/* File: rtl/comparator_channel.sv */
`timescale 1ns/1ps
// One comparator: synchroniser, edge flags, output gating, settle timer
module comparator_channel #(
  parameter int settle_count = dual_comparator_pkg::settle_cycles
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Analog side
  input wire logic raw_in,
  // Control
  input wire logic enable_in,
  input wire logic rise_clear_in,
  input wire logic fall_clear_in,
  // Status
  output logic state_out,
  output logic rise_flag_out,
  output logic fall_flag_out,
  output logic settled_out
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic [15:0] settle_reg;
  logic rise_event;
  logic fall_event;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Disabled output reads low; no edges while off
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_out <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      state_out <= enable_in & sync2_reg;
      prev_reg <= state_out;
    end
  end

  assign rise_event = enable_in & state_out & ~prev_reg;
  assign fall_event = enable_in & ~state_out & prev_reg;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rise_flag_out <= 1'b0;
      fall_flag_out <= 1'b0;
    end else begin
      if (rise_event) begin
        rise_flag_out <= 1'b1;
      end else if (rise_clear_in) begin
        rise_flag_out <= 1'b0;
      end
      if (fall_event) begin
        fall_flag_out <= 1'b1;
      end else if (fall_clear_in) begin
        fall_flag_out <= 1'b0;
      end
    end
  end

  // Settle timer restarts on each enable
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      settle_reg <= 16'h0000;
      settled_out <= 1'b0;
    end else if (!enable_in) begin
      settle_reg <= 16'h0000;
      settled_out <= 1'b0;
    end else if (settle_reg < 16'(settle_count)) begin
      settle_reg <= settle_reg + 16'h0001;
      settled_out <= 1'b0;
    end else begin
      settled_out <= 1'b1;
    end
  end

  a_rise_sets: assert property (@(posedge mclk_in) disable iff (reset_in)
    rise_event |=> rise_flag_out) else $error("rise flag not set");
  a_fall_sets: assert property (@(posedge mclk_in) disable iff (reset_in)
    fall_event |=> fall_flag_out) else $error("fall flag not set");
  a_flag_sticky: assert property (@(posedge mclk_in) disable iff (reset_in)
    rise_flag_out && !rise_clear_in |=> rise_flag_out) else $error("rise flag lost");
  a_off_low: assert property (@(posedge mclk_in) disable iff (reset_in)
    !enable_in |=> !state_out) else $error("output not low when off");
  a_off_quiet: assert property (@(posedge mclk_in) disable iff (reset_in)
    !enable_in && !rise_flag_out ##1 !enable_in |-> !rise_flag_out)
    else $error("flag set while off");
  a_sync_lag: assert property (@(posedge mclk_in) disable iff (reset_in)
    enable_in [*3] |-> state_out == $past(raw_in, 3)) else $error("sync lag wrong");
  a_settle_late: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(enable_in) |-> !settled_out [*8]) else $error("settled too soon");
  c_rise: cover property (@(posedge mclk_in) rise_event);
  c_fall: cover property (@(posedge mclk_in) fall_event);
  c_set_and_clear: cover property (@(posedge mclk_in) rise_event && rise_clear_in);
endmodule : comparator_channel

/* File: rtl/dual_comparator_control.sv */
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Rising output edge sets rising flag
// - Falling output edge sets falling flag
// - Flags stay set until CPU clears
// - Interrupt events on both edges; no interrupt output here, only the rising and falling flags
// - Output state bit readable any time
// - Enable bit switches each comparator independently
// - Disabled comparator pin output held low
// - Disabled comparator raises no interrupt events
// - Output unsettled for 20 us after enable
// - Hysteresis in low four control bits
// - Negative hysteresis: 10, 4, 2, 0 mV
// - Positive hysteresis field, same choices
// - First comparator selectable as reset source
// - Second identical, own control register
// - Second never requests reset
// - Pin driver open-drain or push-pull
// - State one when plus above minus
module dual_comparator_control #(
  parameter int settle_count = dual_comparator_pkg::settle_cycles
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Analog comparator outputs (asynchronous)
  input wire logic first_raw_in,
  input wire logic second_raw_in,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Analog control
  output logic first_enable_out,
  output logic second_enable_out,
  output logic [1:0] first_pos_hyst_out,
  output logic [1:0] first_neg_hyst_out,
  output logic [1:0] second_pos_hyst_out,
  output logic [1:0] second_neg_hyst_out,
  // Pin drivers
  output logic first_pin_out,
  output logic first_pin_oe_out,
  output logic second_pin_out,
  output logic second_pin_oe_out,
  // Reset controller and settle status
  output logic reset_request_out,
  output logic first_settled_out,
  output logic second_settled_out
);
  localparam int ch = 2;

  logic [7:0] ctrl_reg [ch];
  logic [7:0] misc_reg;
  logic [ch-1:0] raw;
  logic [ch-1:0] state;
  logic [ch-1:0] rise_flag;
  logic [ch-1:0] fall_flag;
  logic [ch-1:0] settled;
  logic [ch-1:0] rise_clear;
  logic [ch-1:0] fall_clear;
  logic [ch-1:0] push_pull;
  logic [3:0] aw_reg;
  logic aw_full_reg;
  logic [31:0] w_reg;
  logic [3:0] ws_reg;
  logic w_full_reg;
  logic do_write;
  logic [2:0] aw_sel;

  assign raw = {second_raw_in, first_raw_in};
  assign push_pull = {misc_reg[dual_comparator_pkg::second_push_pull_pos],
                      misc_reg[dual_comparator_pkg::first_push_pull_pos]};

  // Address decoding, shared by read and write paths
  function automatic logic [2:0] decode(input logic [3:0] addr);
    unique case (addr)
      dual_comparator_pkg::first_control_addr: decode = 3'h1;
      dual_comparator_pkg::second_control_addr: decode = 3'h2;
      dual_comparator_pkg::misc_control_addr: decode = 3'h4;
      default: decode = 3'h0;
    endcase
  endfunction : decode

  // Held write address decoded once for every register that listens
  assign aw_sel = decode(aw_reg);

  // Write path: address and data taken in either order
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_out;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_reg <= 4'h0;
      aw_full_reg <= 1'b0;
      s_axi_awready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_reg <= s_axi_awaddr_in;
        aw_full_reg <= 1'b1;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end else if (!aw_full_reg && s_axi_awvalid_in && !s_axi_awready_out) begin
        s_axi_awready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      w_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      w_full_reg <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_wready_out <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_reg <= s_axi_wdata_in;
        ws_reg <= s_axi_wstrb_in;
        w_full_reg <= 1'b1;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end else if (!w_full_reg && s_axi_wvalid_in && !s_axi_wready_out) begin
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= dual_comparator_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (decode(aw_reg) == 3'h0) ? dual_comparator_pkg::resp_slverr
                                                  : dual_comparator_pkg::resp_okay;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Control registers; status bits are not stored here
  generate
    for (genvar i = 0; i < ch; i++) begin : g_ctrl
      logic hit;
      assign hit = do_write && ws_reg[0] && aw_sel[i];
      // Writing zero clears a flag; writing one leaves it
      assign rise_clear[i] = hit && !w_reg[dual_comparator_pkg::rising_flag_pos];
      assign fall_clear[i] = hit && !w_reg[dual_comparator_pkg::falling_flag_pos];
      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          ctrl_reg[i] <= dual_comparator_pkg::control_reset;
        end else if (hit) begin
          ctrl_reg[i][dual_comparator_pkg::enable_bit_pos] <=
            w_reg[dual_comparator_pkg::enable_bit_pos];
          ctrl_reg[i][3:0] <= w_reg[3:0];
        end
      end

      comparator_channel #(
        .settle_count(settle_count)
      ) u_channel (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .raw_in(raw[i]),
        .enable_in(ctrl_reg[i][dual_comparator_pkg::enable_bit_pos]),
        .rise_clear_in(rise_clear[i]),
        .fall_clear_in(fall_clear[i]),
        .state_out(state[i]),
        .rise_flag_out(rise_flag[i]),
        .fall_flag_out(fall_flag[i]),
        .settled_out(settled[i])
      );
    end
  endgenerate

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      misc_reg <= dual_comparator_pkg::misc_reset;
    end else if (do_write && ws_reg[0] && aw_sel[2]) begin
      misc_reg <= {5'h00, w_reg[2:0]};
    end
  end

  // Registered outputs toward the analog macro and pins
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      first_enable_out <= 1'b0;
      second_enable_out <= 1'b0;
      first_pos_hyst_out <= 2'h0;
      first_neg_hyst_out <= 2'h0;
      second_pos_hyst_out <= 2'h0;
      second_neg_hyst_out <= 2'h0;
    end else begin
      first_enable_out <= ctrl_reg[0][dual_comparator_pkg::enable_bit_pos];
      second_enable_out <= ctrl_reg[1][dual_comparator_pkg::enable_bit_pos];
      first_pos_hyst_out <= ctrl_reg[0][dual_comparator_pkg::pos_hyst_lsb +: 2];
      first_neg_hyst_out <= ctrl_reg[0][dual_comparator_pkg::neg_hyst_lsb +: 2];
      second_pos_hyst_out <= ctrl_reg[1][dual_comparator_pkg::pos_hyst_lsb +: 2];
      second_neg_hyst_out <= ctrl_reg[1][dual_comparator_pkg::neg_hyst_lsb +: 2];
    end
  end

  // Open-drain drives only the low level; state is already low when off
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      first_pin_out <= 1'b0;
      first_pin_oe_out <= 1'b0;
      second_pin_out <= 1'b0;
      second_pin_oe_out <= 1'b0;
    end else begin
      first_pin_out <= state[0];
      first_pin_oe_out <= push_pull[0] | ~state[0];
      second_pin_out <= state[1];
      second_pin_oe_out <= push_pull[1] | ~state[1];
    end
  end

  // Reset request on a low output, only once settled to avoid power-up trips
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reset_request_out <= 1'b0;
      first_settled_out <= 1'b0;
      second_settled_out <= 1'b0;
    end else begin
      reset_request_out <= misc_reg[dual_comparator_pkg::reset_source_pos] &
                           settled[0] & ~state[0];
      first_settled_out <= settled[0];
      second_settled_out <= settled[1];
    end
  end

  // Read path
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= dual_comparator_pkg::resp_okay;
    end else begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_rvalid_out) begin
        if (s_axi_rready_in) begin
          s_axi_rvalid_out <= 1'b0;
        end
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= dual_comparator_pkg::resp_okay;
        unique case (decode(s_axi_araddr_in))
          3'h1: s_axi_rdata_out <= {24'h000000, ctrl_reg[0][7], state[0],
                                    rise_flag[0], fall_flag[0], ctrl_reg[0][3:0]};
          3'h2: s_axi_rdata_out <= {24'h000000, ctrl_reg[1][7], state[1],
                                    rise_flag[1], fall_flag[1], ctrl_reg[1][3:0]};
          3'h4: s_axi_rdata_out <= {24'h000000, 1'b0, settled, misc_reg[4:0]};
          default: begin
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= dual_comparator_pkg::resp_slverr;
          end
        endcase
      end else if (s_axi_arvalid_in) begin
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  a_reset_gate: assert property (@(posedge mclk_in) disable iff (reset_in)
    !misc_reg[dual_comparator_pkg::reset_source_pos] |=> !reset_request_out)
    else $error("reset request without source select");
  a_high_noreset: assert property (@(posedge mclk_in) disable iff (reset_in)
    state[0] |=> !reset_request_out) else $error("reset request while output high");
  a_second_ignored: assert property (@(posedge mclk_in) disable iff (reset_in)
    $stable(state[0]) && $stable(settled[0]) && $stable(misc_reg) |=> $stable(reset_request_out))
    else $error("reset request moved by second comparator");
  a_pin_off_low: assert property (@(posedge mclk_in) disable iff (reset_in)
    !ctrl_reg[0][7] ##1 !ctrl_reg[0][7] |=> !first_pin_out)
    else $error("pin high while disabled");
  a_open_drain: assert property (@(posedge mclk_in) disable iff (reset_in)
    !push_pull[0] && state[0] |=> !first_pin_oe_out) else $error("open drain drives high");
  a_write_answer: assert property (@(posedge mclk_in) disable iff (reset_in)
    do_write |=> s_axi_bvalid_out) else $error("no write response");

  // Second channel mirrors the first at the pins; push-pull drive checked on the first only
  a_second_pin_low: assert property (@(posedge mclk_in) disable iff (reset_in)
    !ctrl_reg[1][7] ##1 !ctrl_reg[1][7] |=> !second_pin_out)
    else $error("second pin high while disabled");
  a_second_drain: assert property (@(posedge mclk_in) disable iff (reset_in)
    !push_pull[1] && state[1] |=> !second_pin_oe_out)
    else $error("second open drain drives high");
  a_push_pull_drive: assert property (@(posedge mclk_in) disable iff (reset_in)
    push_pull[0] |=> first_pin_oe_out) else $error("push-pull pin not driven");

  // Control outputs follow the registers
  a_enable_follows: assert property (@(posedge mclk_in) disable iff (reset_in)
    ctrl_reg[0][7] != ctrl_reg[1][7] |=> first_enable_out != second_enable_out)
    else $error("enables not independent");
  a_hyst_follows: assert property (@(posedge mclk_in) disable iff (reset_in)
    $stable(ctrl_reg[0]) |-> {first_pos_hyst_out, first_neg_hyst_out} == ctrl_reg[0][3:0])
    else $error("hysteresis code differs");

  // Bus answers
  a_bad_addr_resp: assert property (@(posedge mclk_in) disable iff (reset_in)
    do_write && aw_sel == 3'h0 |=> s_axi_bresp_out == dual_comparator_pkg::resp_slverr)
    else $error("unmapped write not refused");
  a_bresp_holds: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  a_read_answer: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_axi_arvalid_in && s_axi_arready_out && !s_axi_rvalid_out |=> s_axi_rvalid_out)
    else $error("no read response");
  a_rdata_holds: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data not held");

  c_reset_req: cover property (@(posedge mclk_in) reset_request_out);
  c_both_on: cover property (@(posedge mclk_in) first_enable_out && second_enable_out);
endmodule : dual_comparator_control

/* File: testbench/analog_source_model.sv */
`timescale 1ns/1ps
module analog_source_model (
  // Clock
  input wire logic mclk_in,
  // Input voltages in millivolts
  input wire logic [11:0] first_plus_in,
  input wire logic [11:0] first_minus_in,
  input wire logic [11:0] second_plus_in,
  input wire logic [11:0] second_minus_in,
  // Enables from the control logic
  input wire logic first_enable_in,
  input wire logic second_enable_in,
  // Raw comparator outputs
  output logic first_raw_out,
  output logic second_raw_out
);
  logic chatter_reg = 1'b0;
  // A shut-down comparator gives no defined level, so it chatters
  always_ff @(posedge mclk_in) begin
    chatter_reg <= ~chatter_reg;
  end
  always_comb begin
    first_raw_out = first_enable_in ? (first_plus_in > first_minus_in) : chatter_reg;
    second_raw_out = second_enable_in ? (second_plus_in > second_minus_in) : ~chatter_reg;
  end
endmodule : analog_source_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int settle = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [11:0] plus_mv [2];
  logic [11:0] minus_mv [2];
  wire awready, wready, bvalid, arready, rvalid, en0, en1, pin0, oe0, pin1, oe1;
  wire rstreq, st0, st1, raw0, raw1;
  wire [1:0] bresp, rresp, ph0, nh0, ph1, nh1;
  wire [31:0] rdata;
  int num_errors = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  analog_source_model partner (.mclk_in(clk), .first_plus_in(plus_mv[0]),
    .first_minus_in(minus_mv[0]), .second_plus_in(plus_mv[1]), .second_minus_in(minus_mv[1]),
    .first_enable_in(en0), .second_enable_in(en1), .first_raw_out(raw0), .second_raw_out(raw1));

  dual_comparator_control #(.settle_count(settle)) DUT (.mclk_in(clk), .reset_in(rst),
    .first_raw_in(raw0), .second_raw_in(raw1), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .first_enable_out(en0), .second_enable_out(en1),
    .first_pos_hyst_out(ph0), .first_neg_hyst_out(nh0), .second_pos_hyst_out(ph1),
    .second_neg_hyst_out(nh1), .first_pin_out(pin0), .first_pin_oe_out(oe0),
    .second_pin_out(pin1), .second_pin_oe_out(oe1), .reset_request_out(rstreq),
    .first_settled_out(st0), .second_settled_out(st1));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ad, wd;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    for (n = 0; n < 50 && !(ad && wd); n++) begin
      @(posedge clk);
      if (awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    check(34'(n < 50), 34'h1, "write answered");
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && arready !== 1'b1; n++) @(posedge clk);
    arvalid <= 1'b0;
    for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    check(34'(n < 50), 34'h1, "read answered");
  endtask : rd

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check({r, d}, {dual_comparator_pkg::resp_okay, 24'h0, e}, "register read");
  endtask : rdchk

  task automatic wrok(input logic [3:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(34'(r), 34'(dual_comparator_pkg::resp_okay), "write response");
  endtask : wrok

  task automatic setv(input int i, input logic [11:0] v);
    @(posedge clk);
    plus_mv[i] <= v;
    cyc(8);
  endtask : setv

  task automatic test_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdchk(4'h0, 8'h00);
    rdchk(4'h4, 8'h00);
    rdchk(4'h8, 8'h00);
    check({en0, en1, pin0, rstreq}, 34'h0, "outputs after reset");
    rd(4'hc, d, r);
    check({r, d}, {dual_comparator_pkg::resp_slverr, 32'h0}, "unmapped read");
    wr(4'hc, 8'hff, r);
    check(34'(r), 34'(dual_comparator_pkg::resp_slverr), "unmapped write");
    $display("test reset done");
  endtask : test_reset

  task automatic test_hyst();
    wrok(4'h0, 8'h80);
    wrok(4'h4, 8'h80);
    cyc(settle + 4);
    for (int i = 0; i < 16; i++) begin
      wrok(4'h0, 8'h80 | 8'(i));
      wrok(4'h4, 8'h80 | 8'(15 - i));
      cyc(1);
      check({ph0, nh0}, 34'(i), "first hysteresis");
      check({ph1, nh1}, 34'(15 - i), "second hysteresis");
      check({en0, en1}, 34'h3, "enables");
      rdchk(4'h0, 8'h80 | 8'(i));
    end
    $display("test hysteresis done");
  endtask : test_hyst

  task automatic test_settle();
    wrok(4'h0, 8'h00);
    wrok(4'h0, 8'h80);
    check({st0, st1}, 34'h1, "first unsettled, second kept");
    cyc(settle + 4);
    check(34'(st0), 34'h1, "first settled");
    rdchk(4'h8, 8'h60);
    $display("test settle done");
  endtask : test_settle

  task automatic test_edges();
    logic [3:0] a;
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 4'h0 : 4'h4;
      wrok(a, 8'h80);
      setv(i, 12'h0c8);
      rdchk(a, 8'he0);
      setv(i, 12'h000);
      rdchk(a, 8'hb0);
      setv(i, 12'h0c8);
      rdchk(a, 8'hf0);
      wrok(a, 8'h90);
      rdchk(a, 8'hd0);
      setv(i, 12'h000);
    end
    $display("test edges done");
  endtask : test_edges

  task automatic test_disable();
    wrok(4'h0, 8'h00);
    setv(0, 12'h0c8);
    check(34'(pin0), 34'h0, "disabled pin");
    setv(0, 12'h000);
    setv(0, 12'h0c8);
    rdchk(4'h0, 8'h00);
    check({en0, en1}, 34'h1, "independent enable");
    setv(0, 12'h000);
    $display("test disable done");
  endtask : test_disable

  task automatic test_pins();
    wrok(4'h0, 8'h80);
    cyc(settle + 4);
    wrok(4'h8, 8'h06);
    setv(0, 12'h0c8);
    check({pin0, oe0}, 34'h3, "push-pull high");
    setv(1, 12'h0c8);
    check({pin1, oe1}, 34'h3, "second push-pull high");
    setv(1, 12'h000);
    wrok(4'h8, 8'h00);
    cyc(4);
    check(34'(oe0), 34'h0, "open-drain released");
    setv(0, 12'h000);
    check({pin0, oe0}, 34'h1, "open-drain low");
    check({pin1, oe1}, 34'h1, "second open-drain low");
    wrok(4'h8, 8'h01);
    cyc(4);
    check(34'(rstreq), 34'h1, "reset request");
    setv(0, 12'h0c8);
    check(34'(rstreq), 34'h0, "no request from second");
    rdchk(4'h8, 8'h61);
    $display("test pins done");
  endtask : test_pins

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    plus_mv[0] = 12'h000;
    plus_mv[1] = 12'h000;
    minus_mv[0] = 12'h064;
    minus_mv[1] = 12'h064;
    cyc(20);
    rst <= 1'b0;
    test_reset();
    test_hyst();
    test_settle();
    test_edges();
    test_disable();
    test_pins();
    final_report();
  end

  // Whole run needs roughly 600 cycles
  initial begin
    cyc(6000);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule : tb_top
